// >>> fid_cfg.svh
`ifndef FID_CFG_SVH
`define FID_CFG_SVH

// ==========================================================================
// clock and timing
`define FID_CLK_MHZ     125
`define FID_NS_CYC(ns)  ((((ns) * `FID_CLK_MHZ) + 999) / 1000)
`define FID_T_WP_NS     100
`define FID_T_WPH_NS    100
`define FID_T_RC_NS     90
`define FID_T_RSTP_NS   500
`define FID_T_RST_US    1
`define FID_T_PURD_US   100
`define FID_T_PUWR_MS   5
`define FID_T_BP_US     50
`define FID_SYNC_CYC    3
`define FID_WP_CYC      `FID_NS_CYC(`FID_T_WP_NS)
`define FID_WPH_CYC     `FID_NS_CYC(`FID_T_WPH_NS)
`define FID_RD_CYC      (`FID_NS_CYC(`FID_T_RC_NS) + `FID_SYNC_CYC)
`define FID_RSTP_CYC    `FID_NS_CYC(`FID_T_RSTP_NS)
`define FID_TRST_CYC    (`FID_T_RST_US * `FID_CLK_MHZ)
`define FID_PURD_CYC    (`FID_T_PURD_US * `FID_CLK_MHZ)
`define FID_PUWR_CYC    (`FID_T_PUWR_MS * 1000 * `FID_CLK_MHZ)
`define FID_BP_CYC      (`FID_T_BP_US * `FID_CLK_MHZ)

// ==========================================================================
// command addresses and codes
`define FID_CMD_AMASK   18'h07FFF
`define FID_UNLK1_ADDR  18'h05555
`define FID_UNLK2_ADDR  18'h02AAA
`define FID_UNLK1_DATA  8'hAA
`define FID_UNLK2_DATA  8'h55
`define FID_PROG_CMD    8'hA0
`define FID_ID_CMD      8'h90
`define FID_EXIT_CMD    8'hF0
`define FID_EXIT_ADDR   18'h00000
`define FID_MFR_ADDR    18'h00000
`define FID_DEV_ADDR    18'h00001
`define FID_LOCK_ADDR   18'h00002
`define FID_LOCK_ON     8'hFF
`define FID_LOCK_OFF    8'hFE

`endif

// >>> fid_flash_model.sv
`timescale 1ns/1ps
// ============================================================
// flash device model
module fid_flash_model
   import fid_pkg::*;
#(
   parameter logic [7:0] MFR_CODE = 8'h3C, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'hC3, // arbitrary value
   parameter int         PU_RD_NS = 160,
   parameter int         PU_WR_NS = 3200,
   parameter int         RST_NS   = 1000,
   parameter int         RSTP_NS  = 500,
   parameter int         BP_NS    = 40
) (
   // power and lockout state
   input  wire logic      pwr_i,
   input  wire logic      lock_i,
   // flash pins
   input  wire fid_pins_t pins_i,
   output logic [7:0]     dq_o,
   // observation
   output logic           id_o,
   output int             wr_cnt_o,
   output int             viol_o
);
   logic [7:0]  mem [logic [17:0]];
   logic [1:0]  step_q;
   logic        prog_q;
   logic [7:0]  rd_q;
   logic [7:0]  pdat_q;
   logic [7:0]  d;
   logic [17:0] a;
   logic        rd_en;
   logic        wr_en;
   realtime     pwr_t, rst_lo_t, rst_hi_t, prog_t;

   function automatic logic [7:0] arr(input logic [17:0] x);
      return mem.exists(x) ? mem[x] : 8'hFF;
   endfunction : arr

   function automatic logic busy();
      return $realtime < prog_t + BP_NS;
   endfunction : busy

   initial begin
      {step_q, prog_q, id_o, rd_q, pdat_q} = '0;
      {wr_cnt_o, viol_o} = '0;
      pwr_t    = 0.0;
      rst_lo_t = 0.0;
      rst_hi_t = 0.0;
      prog_t = -1.0e9;
   end

   // a released bus shows the inverse, never a stale value
   assign rd_en = pwr_i && pins_i.rst_n && !pins_i.ce_n && !pins_i.oe_n;
   assign dq_o  = rd_en ? rd_q : ~rd_q;

   always @(negedge pwr_i or negedge pins_i.rst_n) begin
      step_q   = 2'h0;
      prog_q   = 1'b0;
      id_o     = 1'b0;
      rst_lo_t = $realtime;
   end
   always @(posedge pwr_i) pwr_t = $realtime;
   always @(posedge pins_i.rst_n) begin
      if ($realtime - rst_lo_t < RSTP_NS) viol_o++;
      rst_hi_t = $realtime;
   end
   always @(negedge pins_i.ce_n) begin
      if (pwr_i && $realtime - rst_hi_t < RST_NS) viol_o++;
   end

   always @(posedge rd_en) begin
      if ($realtime - pwr_t < PU_RD_NS || pins_i.dq_oe) viol_o++;
      if (busy()) rd_q = {~pdat_q[7], pdat_q[6:0]};
      else if (id_o && pins_i.addr == 18'h00000) rd_q = MFR_CODE;
      else if (id_o && pins_i.addr == 18'h00001) rd_q = DEV_CODE;
      else if (id_o && pins_i.addr == 18'h00002) rd_q = lock_i ? 8'hFF : 8'hFE;
      else if (id_o) viol_o++;
      else rd_q = arr(pins_i.addr);
   end

   // a write ends when either strobe rises; the host may raise both together
   assign wr_en = !pins_i.ce_n && !pins_i.we_n;

   always @(negedge wr_en) begin
      if (pwr_i && pins_i.rst_n) begin
         wr_cnt_o++;
         d = pins_i.dq;
         a = pins_i.addr;
         if (!pins_i.dq_oe || $realtime - pwr_t < PU_WR_NS || busy()) viol_o++;
         if (prog_q) begin
            mem[a] = arr(a) & d;
            pdat_q = d;
            prog_t = $realtime;
            prog_q = 1'b0;
         end else if (a[17:15] != 3'h0) viol_o++;
         else if (d == 8'hF0) begin
            id_o   = 1'b0;
            step_q = 2'h0;
         end else if (id_o) viol_o++;
         else if (step_q == 2'h0 && a == 18'h05555 && d == 8'hAA) step_q = 2'h1;
         else if (step_q == 2'h1 && a == 18'h02AAA && d == 8'h55) step_q = 2'h2;
         else if (step_q == 2'h2 && a == 18'h05555) begin
            id_o   = d == 8'h90;
            prog_q = d == 8'hA0;
            step_q = 2'h0;
         end else step_q = 2'h0;
      end
   end
endmodule : fid_flash_model

// >>> fid_host_ctrl.sv
`timescale 1ns/1ps
`include "fid_cfg.svh"
module fid_host_ctrl
   import fid_pkg::*;
#(
   parameter logic [19:0] PU_RD_CYC = 20'(`FID_PURD_CYC),
   parameter logic [19:0] PU_WR_CYC = 20'(`FID_PUWR_CYC),
   parameter logic [19:0] BP_CYC    = 20'(`FID_BP_CYC)
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // user command
   input  wire logic       cmd_valid_i,
   input  wire fid_cmd_t   cmd_i,
   output logic            cmd_ready_o,
   output logic            wr_ok_o,
   // user answer
   output logic            rsp_valid_o,
   output fid_rsp_t        rsp_o,
   output logic            id_mode_o,
   // flash pins
   output fid_pins_t       fl_o,
   input  wire logic [7:0] fl_dq_i
);

   fid_state_t  state_q;
   fid_cmd_t    cmd_q;
   fid_pins_t   pins_q;
   fid_rsp_t    rsp_q;
   fid_step_t   cur;
   logic [2:0]  idx_q;
   logic        ld_q;
   logic [19:0] ld_cnt_q;
   logic        tmr_done;
   logic        ready_q;
   logic        take;
   logic        step_end;
   logic        wr_lo_end;
   logic        fin;
   logic        rsp_valid_q;
   logic        id_mode_q;
   logic [19:0] pu_cnt_q;
   logic        rd_ok_q;
   logic        wr_ok_q;
   logic [7:0]  dq_m_q;
   logic [7:0]  dq_s_q;
   logic [7:0]  since_rst_q;
   logic [7:0]  low_cnt_q;

   // ========================================================================
   // bus step script per operation
   function automatic fid_step_t fid_script(input fid_op_t     op,
                                            input logic [2:0]  idx,
                                            input logic [17:0] a,
                                            input logic [7:0]  d);
      fid_step_t s;
      s = '{is_wr: 1'b1, addr: `FID_EXIT_ADDR, data: `FID_EXIT_CMD, last: 1'b0};
      if (idx == 3'h0 && op != FID_OP_READ && op != FID_OP_EXIT) begin
         s.addr = `FID_UNLK1_ADDR;
         s.data = `FID_UNLK1_DATA;
      end else if (idx == 3'h1 && op != FID_OP_READ && op != FID_OP_EXIT) begin
         s.addr = `FID_UNLK2_ADDR;
         s.data = `FID_UNLK2_DATA;
      end else begin
         case (op)
            FID_OP_READ: begin
               s.is_wr = 1'b0;
               s.addr  = a;
               s.last  = 1'b1;
            end
            FID_OP_PROG: begin
               s.addr = (idx == 3'h2) ? `FID_UNLK1_ADDR : a;
               s.data = (idx == 3'h2) ? `FID_PROG_CMD : d;
               s.last = (idx == 3'h3);
            end
            FID_OP_IDENT: begin
               case (idx)
                  3'h2: begin
                     s.addr = `FID_UNLK1_ADDR;
                     s.data = `FID_ID_CMD;
                  end
                  3'h3: begin
                     s.is_wr = 1'b0;
                     s.addr  = `FID_MFR_ADDR;
                  end
                  3'h4: begin
                     s.is_wr = 1'b0;
                     s.addr  = `FID_DEV_ADDR;
                  end
                  3'h5: begin
                     s.is_wr = 1'b0;
                     s.addr  = `FID_LOCK_ADDR;
                  end
                  default: s.last = 1'b1;
               endcase
            end
            default: s.last = 1'b1;
         endcase
      end
      // command cycles only decode A14-A0; the program data write keeps the full address
      if (s.is_wr && !(op == FID_OP_PROG && idx == 3'h3)) begin
         s.addr = s.addr & `FID_CMD_AMASK;
      end
      return s;
   endfunction : fid_script

   always_comb begin
      cur = fid_script(cmd_q.op, idx_q, cmd_q.addr, cmd_q.data);
   end

   // ========================================================================
   // phase timer
   fid_wait_tmr u_tmr (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .load_i  (ld_q),
      .count_i (ld_cnt_q),
      .done_o  (tmr_done)
   );

   // writes wait for the long power-up delay; reads and reset wait only for the read delay (ready_q)
   assign take      = cmd_valid_i && ready_q &&
                      (cmd_i.op == FID_OP_READ || cmd_i.op == FID_OP_RESET || wr_ok_q);
   assign step_end  = (state_q == ST_WR_HI || state_q == ST_RD) && !ld_q && tmr_done;
   assign wr_lo_end = (state_q == ST_WR_LO) && !ld_q && tmr_done;
   assign fin       = (step_end && cur.last && cmd_q.op != FID_OP_PROG) ||
                      (state_q == ST_BUSY && !ld_q && tmr_done);

   // ========================================================================
   // power-up delays, host reset stands for power-up
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pu_cnt_q <= 20'h00000;
         rd_ok_q  <= 1'b0;
         wr_ok_q  <= 1'b0;
      end else begin
         if (pu_cnt_q != PU_WR_CYC) begin
            pu_cnt_q <= pu_cnt_q + 20'h00001;
         end
         rd_ok_q <= (pu_cnt_q >= PU_RD_CYC);
         wr_ok_q <= (pu_cnt_q >= PU_WR_CYC);
      end
   end

   // ========================================================================
   // data pins are asynchronous to clk_i
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dq_m_q <= 8'h00;
         dq_s_q <= 8'h00;
      end else begin
         dq_m_q <= fl_dq_i;
         dq_s_q <= dq_m_q;
      end
   end

   // ========================================================================
   // sequencer
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q  <= ST_RST_LO;
         idx_q    <= 3'h0;
         cmd_q    <= '0;
         ld_q     <= 1'b1;
         ld_cnt_q <= 20'(`FID_RSTP_CYC);
         ready_q  <= 1'b0;
         pins_q   <= '{addr: 18'h00000, dq: 8'h00, dq_oe: 1'b0, ce_n: 1'b1,
                       oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0};
      end else begin
         ld_q    <= 1'b0;
         ready_q <= 1'b0;
         unique case (state_q)
            ST_RST_LO: if (!ld_q && tmr_done) begin
               pins_q.rst_n <= 1'b1;
               ld_q         <= 1'b1;
               ld_cnt_q     <= 20'(`FID_TRST_CYC);
               state_q      <= ST_RST_WT;
            end
            ST_RST_WT: if (!ld_q && tmr_done) begin
               state_q <= ST_IDLE;
            end
            ST_IDLE: begin
               ready_q <= rd_ok_q && !take;
               if (take) begin
                  cmd_q <= cmd_i;
                  idx_q <= 3'h0;
                  if (cmd_i.op == FID_OP_RESET) begin
                     pins_q.rst_n <= 1'b0;
                     ld_q         <= 1'b1;
                     ld_cnt_q     <= 20'(`FID_RSTP_CYC);
                     state_q      <= ST_RST_LO;
                  end else begin
                     state_q <= ST_NEXT;
                  end
               end
            end
            ST_NEXT: begin
               pins_q.addr <= cur.addr;
               pins_q.ce_n <= 1'b0;
               ld_q        <= 1'b1;
               if (cur.is_wr) begin
                  pins_q.dq    <= cur.data;
                  pins_q.dq_oe <= 1'b1;
                  pins_q.we_n  <= 1'b0;
                  ld_cnt_q     <= 20'(`FID_WP_CYC);
                  state_q      <= ST_WR_LO;
               end else begin
                  pins_q.oe_n <= 1'b0;
                  ld_cnt_q    <= 20'(`FID_RD_CYC);
                  state_q     <= ST_RD;
               end
            end
            ST_WR_LO: if (wr_lo_end) begin
               pins_q.ce_n <= 1'b1;
               pins_q.we_n <= 1'b1;
               ld_q        <= 1'b1;
               ld_cnt_q    <= 20'(`FID_WPH_CYC);
               state_q     <= ST_WR_HI;
            end
            ST_WR_HI: if (step_end) begin
               pins_q.dq_oe <= 1'b0;
            end
            ST_RD: if (step_end) begin
               pins_q.ce_n <= 1'b1;
               pins_q.oe_n <= 1'b1;
            end
            ST_BUSY: if (!ld_q && tmr_done) begin
               state_q <= ST_IDLE;
            end
         endcase
         if (step_end) begin
            if (!cur.last) begin
               idx_q   <= idx_q + 3'h1;
               state_q <= ST_NEXT;
            end else if (cmd_q.op == FID_OP_PROG) begin
               // device is self-timed; wait its longest program time, no polling
               ld_q     <= 1'b1;
               ld_cnt_q <= BP_CYC;
               state_q  <= ST_BUSY;
            end else begin
               state_q <= ST_IDLE;
            end
         end
      end
   end

   // ========================================================================
   // id mode tracking; the whole id sequence is atomic so no array access
   // can slip in between entry and exit
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         id_mode_q <= 1'b0;
      end else if (state_q == ST_RST_LO) begin
         id_mode_q <= 1'b0;
      end else if (wr_lo_end && pins_q.dq == `FID_EXIT_CMD) begin
         id_mode_q <= 1'b0;
      end else if (wr_lo_end && pins_q.dq == `FID_ID_CMD && cmd_q.op == FID_OP_IDENT) begin
         id_mode_q <= 1'b1;
      end
   end

   // ========================================================================
   // answer capture
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rsp_q       <= '0;
         rsp_valid_q <= 1'b0;
      end else begin
         rsp_valid_q <= fin;
         if (step_end && state_q == ST_RD) begin
            unique case (cur.addr)
               `FID_MFR_ADDR:  if (cmd_q.op == FID_OP_IDENT) rsp_q.mfr <= dq_s_q;
               `FID_DEV_ADDR:  if (cmd_q.op == FID_OP_IDENT) rsp_q.dev <= dq_s_q;
               `FID_LOCK_ADDR: if (cmd_q.op == FID_OP_IDENT) begin
                  rsp_q.lock    <= dq_s_q;
                  rsp_q.lock_on <= (dq_s_q == `FID_LOCK_ON);
               end
               default: ;
            endcase
            if (cmd_q.op == FID_OP_READ) begin
               rsp_q.data <= dq_s_q;
            end
         end
      end
   end

   assign cmd_ready_o = ready_q;
   assign wr_ok_o     = wr_ok_q;
   assign rsp_valid_o = rsp_valid_q;
   assign rsp_o       = rsp_q;
   assign id_mode_o   = id_mode_q;
   assign fl_o        = pins_q;

   // ========================================================================
   // checks
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         since_rst_q <= 8'h00;
         low_cnt_q   <= 8'h00;
      end else begin
         since_rst_q <= !pins_q.rst_n ? 8'h00 :
                        (since_rst_q == 8'hFF) ? since_rst_q : since_rst_q + 8'h01;
         low_cnt_q   <= pins_q.rst_n ? 8'h00 :
                        (low_cnt_q == 8'hFF) ? low_cnt_q : low_cnt_q + 8'h01;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   wr_gate_a: assert property ($fell(pins_q.we_n) |-> wr_ok_q)
      else $error("write strobe before power-up write delay");
   rd_gate_a: assert property ($fell(pins_q.oe_n) |-> rd_ok_q)
      else $error("read strobe before power-up read delay");
   rst_recover_a: assert property ($fell(pins_q.ce_n) |-> since_rst_q >= 8'(`FID_TRST_CYC))
      else $error("chip select too soon after reset release");
   rst_pulse_a: assert property ($rose(pins_q.rst_n) |-> low_cnt_q >= 8'(`FID_RSTP_CYC))
      else $error("flash reset pulse too short");
   cmd_addr_a: assert property ((state_q == ST_WR_LO &&
                                 !(cmd_q.op == FID_OP_PROG && idx_q == 3'h3))
                                |-> pins_q.addr[17:15] == 3'h0)
      else $error("command write outside A14-A0");
   id_exit_a: assert property ($fell(id_mode_q) |->
                               ($past(pins_q.dq) == `FID_EXIT_CMD || $past(state_q) == ST_RST_LO))
      else $error("id mode left without exit write");
   id_entry_a: assert property ($rose(id_mode_q) |->
                                $past(pins_q.addr) == `FID_UNLK1_ADDR && $past(idx_q) == 3'h2)
      else $error("id mode entered off the unlock sequence");
   id_reads_a: assert property ((id_mode_q && $fell(pins_q.oe_n)) |-> pins_q.addr[17:2] == 16'h0000)
      else $error("array read while in id mode");
   prog_wait_a: assert property ($rose(state_q == ST_BUSY) |=> (state_q == ST_BUSY)[*8])
      else $error("program wait cut short");

   id_done_c: cover property (rsp_valid_q && cmd_q.op == FID_OP_IDENT && !id_mode_q);
   prog_done_c: cover property (state_q == ST_BUSY ##1 state_q == ST_IDLE);
   read_done_c: cover property (rsp_valid_q && cmd_q.op == FID_OP_READ);
   reset_done_c: cover property (state_q == ST_RST_WT ##1 state_q == ST_IDLE);

endmodule : fid_host_ctrl

// >>> fid_pkg.sv
package fid_pkg;

   // =======================================================================
   // user command and answer
   typedef enum logic [2:0] {
      FID_OP_READ  = 3'h0,
      FID_OP_PROG  = 3'h1,
      FID_OP_IDENT = 3'h2,
      FID_OP_EXIT  = 3'h3,
      FID_OP_RESET = 3'h4
   } fid_op_t;

   typedef struct packed {
      fid_op_t     op;
      logic [17:0] addr;
      logic [7:0]  data;
   } fid_cmd_t;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] mfr;
      logic [7:0] dev;
      logic [7:0] lock;
      logic       lock_on;
   } fid_rsp_t;

   // =======================================================================
   // flash pins and bus steps
   typedef struct packed {
      logic [17:0] addr;
      logic [7:0]  dq;
      logic        dq_oe;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        rst_n;
   } fid_pins_t;

   typedef struct packed {
      logic        is_wr;
      logic [17:0] addr;
      logic [7:0]  data;
      logic        last;
   } fid_step_t;

   typedef enum logic [7:0] {
      ST_RST_LO = 8'h01,
      ST_RST_WT = 8'h02,
      ST_IDLE   = 8'h04,
      ST_NEXT   = 8'h08,
      ST_WR_LO  = 8'h10,
      ST_WR_HI  = 8'h20,
      ST_RD     = 8'h40,
      ST_BUSY   = 8'h80
   } fid_state_t;

endpackage : fid_pkg

// >>> fid_wait_tmr.sv
`timescale 1ns/1ps
module fid_wait_tmr (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // control
   input  wire logic        load_i,
   input  wire logic [19:0] count_i,
   // status
   output logic             done_o
);

   logic [19:0] cnt_q;

   // ========================================================================
   // down counter, idles at zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 20'h00000;
      end else if (load_i) begin
         cnt_q <= count_i;
      end else if (cnt_q != 20'h00000) begin
         cnt_q <= cnt_q - 20'h00001;
      end
   end

   assign done_o = (cnt_q == 20'h00000);

endmodule : fid_wait_tmr

// >>> flash_id_lockout_detect_tb.sv
`timescale 1ns/1ps
module flash_id_lockout_detect_tb;
   import fid_pkg::*;
   typedef struct packed {
      fid_op_t     op;
      logic [17:0] addr;
      logic [7:0]  data;
      logic [7:0]  exp;
   } fid_row_t;
   localparam fid_row_t ROWS [6] = '{
      '{FID_OP_READ, 18'h00010, 8'h00, 8'hFF},
      '{FID_OP_PROG, 18'h00010, 8'h3C, 8'h00},
      '{FID_OP_READ, 18'h00010, 8'h00, 8'h3C},
      '{FID_OP_PROG, 18'h3FFFF, 8'hA5, 8'h00},
      '{FID_OP_READ, 18'h3FFFF, 8'h00, 8'hA5},
      '{FID_OP_READ, 18'h00001, 8'h00, 8'hFF}};

   logic       clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, wr_ok_o;
   logic       rsp_valid_o, id_mode_o, lock, id_dev;
   fid_cmd_t   cmd_i;
   fid_rsp_t   rsp_o;
   fid_pins_t  fl_o;
   logic [7:0] fl_dq_i, dq_dev;
   int         wr_cnt, viol, err_count, n_compared, cyc, w, n;

   assign fl_dq_i = fl_o.dq_oe ? fl_o.dq : dq_dev;

   fid_host_ctrl #(.PU_RD_CYC(20'd20), .PU_WR_CYC(20'd400), .BP_CYC(20'd10)) i_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
      .cmd_ready_o(cmd_ready_o), .wr_ok_o(wr_ok_o), .rsp_valid_o(rsp_valid_o),
      .rsp_o(rsp_o), .id_mode_o(id_mode_o), .fl_o(fl_o), .fl_dq_i(fl_dq_i));

   // host reset doubles as the flash power rail
   fid_flash_model i_flash (.pwr_i(rst_n_i), .lock_i(lock), .pins_i(fl_o), .dq_o(dq_dev),
      .id_o(id_dev), .wr_cnt_o(wr_cnt), .viol_o(viol));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) cyc <= 0;
      else cyc <= cyc + 1;
   end

   // ============================================================
   // shared tasks
   task chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   task tick;
      @(posedge clk_i);
      #1;
   endtask : tick

   task automatic wait_on(input string name, ref logic sig);
      for (n = 0; n < 2000 && sig !== 1'b1; n++) tick();
      if (n == 2000) begin
         chk(name, 0, 1);
         tally_and_finish();
      end
   endtask : wait_on

   task send(input fid_op_t op, input logic [17:0] a, input logic [7:0] d);
      wait_on("cmd_ready_o", cmd_ready_o);
      cmd_i       = '{op, a, d};
      cmd_valid_i = 1'b1;
      tick();
      cmd_valid_i = 1'b0;
   endtask : send

   task do_op(input fid_op_t op, input logic [17:0] a, input logic [7:0] d);
      send(op, a, d);
      wait_on("rsp_valid_o", rsp_valid_o);
   endtask : do_op

   task power_up;
      rst_n_i = 1'b1;
      wait_on("wr_ok_o", wr_ok_o);
      chk("wr_ok delay low", cyc >= 400, 1);
      chk("wr_ok delay high", cyc <= 404, 1);
   endtask : power_up

   // ============================================================
   // main sequence
   initial begin
      {rst_n_i, cmd_valid_i, cmd_i, lock} = '0;
      {err_count, n_compared} = '0;
      repeat (16) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      wait_on("cmd_ready_o", cmd_ready_o);
      chk("wr_ok early", wr_ok_o, 0);
      cmd_i       = '{FID_OP_PROG, 18'h00020, 8'h00};
      cmd_valid_i = 1'b1;
      repeat (8) begin
         tick();
         chk("refused ready", cmd_ready_o, 1);
         chk("refused rsp", rsp_valid_o, 0);
      end
      cmd_valid_i = 1'b0;
      chk("refused writes", wr_cnt, 0);
      // a reset of zero width would clock every register once instead
      rst_n_i = 1'b0;
      repeat (16) tick();
      power_up();
      $display("test power_up done");

      foreach (ROWS[i]) begin
         do_op(ROWS[i].op, ROWS[i].addr, ROWS[i].data);
         if (ROWS[i].op == FID_OP_READ) chk("read data", rsp_o.data, ROWS[i].exp);
      end
      $display("test rows done");

      for (int l = 0; l < 2; l++) begin
         lock = l[0];
         do_op(FID_OP_IDENT, 18'h00000, 8'h00);
         chk("mfr", rsp_o.mfr, 8'h3C);
         chk("dev", rsp_o.dev, 8'hC3);
         chk("lock", rsp_o.lock, l[0] ? 8'hFF : 8'hFE);
         chk("lock_on", rsp_o.lock_on, l[0]);
         chk("id_mode after", id_mode_o, 0);
         chk("device id after", id_dev, 0);
         do_op(FID_OP_READ, 18'h00000, 8'h00);
         chk("array after id", rsp_o.data, 8'hFF);
      end
      $display("test ident done");

      w = wr_cnt;
      do_op(FID_OP_EXIT, 18'h00000, 8'h00);
      chk("exit writes", wr_cnt - w, 1);
      chk("exit id_mode", id_mode_o, 0);
      send(FID_OP_RESET, 18'h00000, 8'h00);
      do_op(FID_OP_READ, 18'h00010, 8'h00);
      chk("read after reset", rsp_o.data, 8'h3C);
      $display("test exit_reset done");

      send(FID_OP_IDENT, 18'h00000, 8'h00);
      wait_on("id_mode_o", id_mode_o);
      rst_n_i = 1'b0;
      repeat (16) tick();
      chk("id lost device", id_dev, 0);
      chk("id lost host", id_mode_o, 0);
      chk("wr_ok in reset", wr_ok_o, 0);
      power_up();
      do_op(FID_OP_READ, 18'h00000, 8'h00);
      chk("array after power", rsp_o.data, 8'hFF);
      chk("device timing", viol, 0);
      $display("test power_loss done");
      tally_and_finish();
   end
endmodule : flash_id_lockout_detect_tb
